// *** shared/fbod_pkg.sv ***
package fbod_pkg;
    // ------------------------------------------------------------------
    // pin widths and protect address bits
    // ------------------------------------------------------------------
    localparam int ADDR_W      = 20;
    localparam int DATA_W      = 8;
    localparam int BIT_SIX     = 6;
    localparam int BIT_ONE     = 1;
    localparam int BIT_ZERO    = 0;
    localparam int POLL_BIT    = 7;
    localparam int TOGGLE_BIT  = 6;

    // ------------------------------------------------------------------
    // timing in ns and derived clock counts (125 MHz, 8 ns)
    // ------------------------------------------------------------------
    localparam int CLK_NS            = 8;
    localparam int ADDR_ACCESS_NS    = 70;   // address_access_time
    localparam int SELECT_ACCESS_NS  = 70;   // select_access_time
    localparam int RESET_PULSE_NS    = 500;  // reset_pulse_min
    localparam int RESET_HIGH_NS     = 50;   // reset_high_to_read
    localparam int SETUP_NS          = 16;
    localparam int WRITE_PULSE_NS    = 40;
    localparam int GAP_NS            = 24;
    // least times round up
    localparam int ACCESS_CYC  = (ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int SELECT_CYC  = (SELECT_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CYC     = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RH_CYC      = (RESET_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC      = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC     = (GAP_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------------
    // user command codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FBOD_OP_READ      = 3'h0,
        FBOD_OP_WRITE     = 3'h1,
        FBOD_OP_RESET     = 3'h2,
        FBOD_OP_PROTECT   = 3'h3,
        FBOD_OP_UNPROTECT = 3'h4,
        FBOD_OP_STANDBY   = 3'h5
    } fbod_op_t;

    typedef struct packed {
        fbod_op_t             op;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    data;
    } fbod_req_t;

    // control levels driven to the pins, all active low but high_volt
    typedef struct packed {
        logic chip_select_n;
        logic output_gate_n;
        logic write_strobe_n;
        logic hard_clear_n;
        logic high_volt;
    } fbod_ctl_t;

    localparam fbod_ctl_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
endpackage

// *** core/fbod_timer.sv ***
`timescale 1ns/10ps
// down counter: load a count, pulse done when it reaches one
module fbod_timer #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_q;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    assign busy = (cnt_q != '0);
    assign done = (cnt_q == W'(1));

    // load wins over counting so back-to-back phases stay exact
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (busy) begin
            cnt_q <= cnt_q - W'(1);
        end
    end
endmodule // fbod_timer

// *** core/fbod_host.sv ***
`timescale 1ns/10ps
module fbod_host #(
    parameter int ADDR_W = fbod_pkg::ADDR_W,
    parameter int DATA_W = fbod_pkg::DATA_W
) (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire fbod_pkg::fbod_req_t req,
    input  wire logic                req_valid,
    output logic                     req_ready,
    output logic [DATA_W-1:0]        rsp_data,
    output logic                     rsp_valid,
    output logic                     op_done_seen,
    output fbod_pkg::fbod_ctl_t      ctl_pins,
    output logic [ADDR_W-1:0]        address_pins,
    output logic [DATA_W-1:0]        data_out,
    output logic                     data_oe,
    input  wire logic [DATA_W-1:0]   data_in,
    input  wire logic                op_done_flag
);
    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    localparam int TW = 8;

    // the reset, select and access phase counts must fit the timer width
    if (ADDR_W != fbod_pkg::ADDR_W || DATA_W != fbod_pkg::DATA_W ||
        fbod_pkg::RST_CYC >= 2**TW || fbod_pkg::SELECT_CYC >= 2**TW ||
        fbod_pkg::ACCESS_CYC >= 2**TW) begin : g_chk
        $error("fbod_host: pin widths or phase counts out of range");
    end

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_PULSE = 3'b011,
        ST_HOLD  = 3'b010,
        ST_RHIGH = 3'b110
    } fbod_state_t;

    fbod_state_t         state_q, state_d;
    fbod_pkg::fbod_req_t cur_q;
    fbod_pkg::fbod_ctl_t ctl_q, ctl_d;
    logic [ADDR_W-1:0]   addr_q;
    logic [DATA_W-1:0]   dout_q, rdata_q;
    logic                oe_q, rvalid_q, ready_q, done_q;
    logic                standby_q;
    logic                t_load, t_busy, t_done;
    logic [TW-1:0]       t_count;

    // ------------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------------
    wire take     = ready_q && req_valid;
    wire is_read  = cur_q.op == fbod_pkg::FBOD_OP_READ;
    wire is_rst   = cur_q.op == fbod_pkg::FBOD_OP_RESET;
    wire is_prot  = cur_q.op == fbod_pkg::FBOD_OP_PROTECT ||
                    cur_q.op == fbod_pkg::FBOD_OP_UNPROTECT;
    wire is_sby   = cur_q.op == fbod_pkg::FBOD_OP_STANDBY;
    // op of the cycle: a fresh take must not see the last request's op
    wire fbod_pkg::fbod_op_t op_now = take ? req.op : cur_q.op;
    wire drv_now  = op_now == fbod_pkg::FBOD_OP_WRITE ||
                    op_now == fbod_pkg::FBOD_OP_PROTECT ||
                    op_now == fbod_pkg::FBOD_OP_UNPROTECT;
    // access after standby must cover select access time
    wire [TW-1:0] rd_cyc = standby_q ? TW'(fbod_pkg::SELECT_CYC)
                                     : TW'(fbod_pkg::ACCESS_CYC);

    // protect address: bit six picks direction, bits one/zero fixed
    function automatic logic [ADDR_W-1:0] prot_addr(
        input logic [ADDR_W-1:0] a, input logic unprot);
        logic [ADDR_W-1:0] r;
        r = a;
        r[fbod_pkg::BIT_SIX]  = unprot;
        r[fbod_pkg::BIT_ONE]  = 1'b1;
        r[fbod_pkg::BIT_ZERO] = 1'b0;
        return r;
    endfunction

    // control levels for the active phase of each operation
    function automatic fbod_pkg::fbod_ctl_t active_ctl(input fbod_pkg::fbod_op_t o);
        fbod_pkg::fbod_ctl_t c;
        c = fbod_pkg::CTL_IDLE;
        unique case (o)
            fbod_pkg::FBOD_OP_READ: begin
                c.chip_select_n = 1'b0;
                c.output_gate_n = 1'b0;
            end
            fbod_pkg::FBOD_OP_WRITE: begin
                c.chip_select_n  = 1'b0;
                c.write_strobe_n = 1'b0;
            end
            fbod_pkg::FBOD_OP_RESET: c.hard_clear_n = 1'b0;
            fbod_pkg::FBOD_OP_PROTECT, fbod_pkg::FBOD_OP_UNPROTECT: begin
                c.chip_select_n  = 1'b0;
                c.write_strobe_n = 1'b0;
                c.high_volt      = 1'b1;
            end
            default: c = fbod_pkg::CTL_IDLE; // standby, illegal codes
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------------
    // phase timer
    // ------------------------------------------------------------------
    fbod_timer #(.W(TW)) u_timer (
        .clk   (clk),
        .reset (reset),
        .load  (t_load),
        .count (t_count),
        .busy  (t_busy),
        .done  (t_done)
    );

    // ------------------------------------------------------------------
    // sequencer: setup, pulse, hold, optional reset-high wait
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        ctl_d   = ctl_q;
        t_load  = 1'b0;
        t_count = '0;
        unique case (state_q)
            ST_IDLE: if (take) begin
                state_d = ST_SETUP;
                t_load  = 1'b1;
                t_count = TW'(fbod_pkg::SETUP_CYC);
                // high voltage set up before strobes
                ctl_d   = fbod_pkg::CTL_IDLE;
                ctl_d.high_volt = req.op == fbod_pkg::FBOD_OP_PROTECT ||
                                  req.op == fbod_pkg::FBOD_OP_UNPROTECT;
                ctl_d.chip_select_n = req.op == fbod_pkg::FBOD_OP_STANDBY;
            end
            ST_SETUP: if (t_done) begin
                state_d = ST_PULSE;
                ctl_d   = active_ctl(cur_q.op);
                t_load  = 1'b1;
                t_count = is_read ? rd_cyc
                        : is_rst ? TW'(fbod_pkg::RST_CYC)
                        : TW'(fbod_pkg::WP_CYC);
            end
            ST_PULSE: if (t_done) begin
                state_d = ST_HOLD;
                // strobes, gate and clear rise first; select and high voltage release after hold
                ctl_d   = fbod_pkg::CTL_IDLE;
                ctl_d.chip_select_n = is_sby;
                ctl_d.high_volt     = is_prot;
                t_load  = 1'b1;
                t_count = TW'(fbod_pkg::GAP_CYC);
            end
            ST_HOLD: if (t_done) begin
                ctl_d   = fbod_pkg::CTL_IDLE;
                t_load  = is_rst;
                t_count = TW'(fbod_pkg::RH_CYC);
                state_d = is_rst ? ST_RHIGH : ST_IDLE;
            end
            ST_RHIGH: if (t_done) begin
                state_d = ST_IDLE; // ready for a reissue
            end
            default: begin
                state_d = ST_IDLE;
                ctl_d   = fbod_pkg::CTL_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state, pins and request registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            ctl_q   <= fbod_pkg::CTL_IDLE;
            cur_q   <= '0;
        end else begin
            state_q <= state_d;
            ctl_q   <= ctl_d;
            if (take) cur_q <= req;
        end
    end

    // address and data drive; data only in setup and pulse of write-type operations
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr_q <= '0;
            dout_q <= '0;
            oe_q   <= 1'b0;
        end else begin
            if (take) begin
                addr_q <= (req.op == fbod_pkg::FBOD_OP_PROTECT ||
                           req.op == fbod_pkg::FBOD_OP_UNPROTECT)
                        ? prot_addr(req.addr,
                              req.op == fbod_pkg::FBOD_OP_UNPROTECT)
                        : req.addr;
                dout_q <= req.data;
            end
            // never drive while the gate could be low
            oe_q <= (state_d == ST_SETUP || state_d == ST_PULSE) &&
                    ctl_d.output_gate_n && drv_now;
        end
    end

    // capture read data at the end of the access wait
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q   <= '0;
            rvalid_q  <= 1'b0;
            ready_q   <= 1'b0;
            done_q    <= 1'b0;
            standby_q <= 1'b1;
        end else begin
            rvalid_q <= state_q == ST_PULSE && t_done && is_read;
            if (state_q == ST_PULSE && t_done && is_read) rdata_q <= data_in;
            ready_q  <= state_d == ST_IDLE && !take;
            done_q   <= op_done_flag;
            if (state_q == ST_PULSE && t_done)
                standby_q <= is_sby || is_rst;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign req_ready    = ready_q;
    assign rsp_data     = rdata_q;
    assign rsp_valid    = rvalid_q;
    assign op_done_seen = done_q;
    assign ctl_pins     = ctl_q;
    assign address_pins = addr_q;
    assign data_out     = dout_q;
    assign data_oe      = oe_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_no_gate_strobe: assert property (@(posedge clk) disable iff (reset)
        !(!ctl_q.output_gate_n && !ctl_q.write_strobe_n))
        else $error("gate and strobe low together");
    a_no_drive_gate: assert property (@(posedge clk) disable iff (reset)
        !(oe_q && !ctl_q.output_gate_n))
        else $error("host drives data while gate low");
    a_write_select: assert property (@(posedge clk) disable iff (reset)
        !ctl_q.write_strobe_n |-> !ctl_q.chip_select_n && ctl_q.output_gate_n)
        else $error("write strobe without select");
    a_read_clear: assert property (@(posedge clk) disable iff (reset)
        !ctl_q.output_gate_n |-> ctl_q.hard_clear_n && !ctl_q.chip_select_n)
        else $error("read while clear low");
    a_reset_width: assert property (@(posedge clk) disable iff (reset)
        $fell(ctl_q.hard_clear_n) |-> !ctl_q.hard_clear_n [*8])
        else $error("reset pulse too short");
    a_rh_wait: assert property (@(posedge clk) disable iff (reset)
        $rose(ctl_q.hard_clear_n) |-> !req_ready [*7])
        else $error("request taken before reset-high delay");
    a_prot_volt: assert property (@(posedge clk) disable iff (reset)
        (!ctl_q.write_strobe_n && ctl_q.high_volt) |->
            address_pins[fbod_pkg::BIT_ONE] && !address_pins[fbod_pkg::BIT_ZERO])
        else $error("protect address bits wrong");
    a_read_resp: assert property (@(posedge clk) disable iff (reset)
        $fell(ctl_q.output_gate_n) |-> ##[9:10] rsp_valid)
        else $error("read answer off time");

    c_read:    cover property (@(posedge clk) disable iff (reset) rsp_valid);
    c_write:   cover property (@(posedge clk) disable iff (reset)
        $fell(ctl_q.write_strobe_n) && !ctl_q.high_volt);
    c_reset:   cover property (@(posedge clk) disable iff (reset)
        $fell(ctl_q.hard_clear_n));
    c_protect: cover property (@(posedge clk) disable iff (reset)
        $fell(ctl_q.write_strobe_n) && ctl_q.high_volt);
endmodule // fbod_host

// *** testbench/fbod_flash_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// behavioural flash device on the far side of the host pins
// ----------------------------------------------------------------------
module fbod_flash_model #(
    parameter int         ACC_CYC  = 6,
    parameter int         PROG_CYC = 150,
    parameter int         REC_CYC  = 20,
    parameter logic [7:0] ID_CODE  = 8'h6c  // arbitrary value
) (
    input  wire logic                clk,
    input  wire fbod_pkg::fbod_ctl_t ctl,
    input  wire logic [19:0]         addr,
    input  wire logic [7:0]          host_d,
    input  wire logic                host_oe,
    output logic [7:0]               bus,
    output logic                     op_done_flag
);
    logic [7:0]  mem [16];
    logic [7:0]  cmd_d, pd_q, dout_q;
    logic [7:0]  last_q = 8'h00;
    logic [19:0] cmd_a, addr_q;
    logic [3:0]  pa_q;
    logic        we_q = 1'b1, oe_q = 1'b1, cmd_v = 1'b0, cmd_hv = 1'b0;
    logic        fast_q = 1'b0, pend_q = 1'b0, id_q = 1'b0, prot_q = 1'b0;
    logic        tog_q = 1'b0, abort_q = 1'b0, ready_q = 1'b0;
    logic        era_q = 1'b0;
    int          sel_cnt = 0, stab_cnt = 0, busy_cnt = 0;
    // decode of the pin levels
    wire sel   = !ctl.chip_select_n && ctl.hard_clear_n;
    wire drive = sel && !ctl.output_gate_n && ready_q;
    wire ready = sel_cnt >= ACC_CYC && stab_cnt >= ACC_CYC;
    wire rise  = !we_q && ctl.write_strobe_n;
    wire fall  = oe_q && !ctl.output_gate_n;
    assign op_done_flag = (busy_cnt == 0);
    // released bus shows the inverse, so a stale byte never passes
    assign bus = host_oe ? host_d : drive ? dout_q : ~last_q;
    initial for (int i = 0; i < 16; i++) mem[i] = 8'h5a ^ (8'(i) * 8'h11);

    // pin sampling, command latches and embedded program
    always @(posedge clk) begin
        last_q   <= bus;
        we_q     <= ctl.write_strobe_n;
        oe_q     <= ctl.output_gate_n;
        addr_q   <= addr;
        ready_q  <= ready;
        sel_cnt  <= sel ? sel_cnt + 1 : 0;
        stab_cnt <= (addr == addr_q) ? stab_cnt + 1 : 0;
        if (ready) dout_q <= (busy_cnt != 0) ? {~pd_q[7], tog_q, 6'h00}
                           : id_q ? ID_CODE : mem[addr[3:0]];
        if (fall && sel && busy_cnt != 0) tog_q <= ~tog_q;
        if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;  // runs deselected
        if (busy_cnt == 1 && !abort_q) mem[pa_q] <= pd_q;
        if (!ctl.write_strobe_n && !ctl.chip_select_n && ctl.output_gate_n) begin
            cmd_a  <= addr;  // latches, gate must be high
            cmd_d  <= bus;
            cmd_hv <= ctl.high_volt;
            cmd_v  <= 1'b1;
        end
        if (!ctl.hard_clear_n) begin
            fast_q <= 1'b0;
            pend_q <= 1'b0;
            id_q   <= 1'b0;
            era_q  <= 1'b0;
            cmd_v  <= 1'b0;
            if (busy_cnt != 0) abort_q <= 1'b1;
            if (busy_cnt > REC_CYC) busy_cnt <= REC_CYC;
        end else if (rise && cmd_v) begin
            cmd_v <= 1'b0;
            if (cmd_hv) begin
                if (cmd_a[1] && !cmd_a[0]) prot_q <= !cmd_a[6];
            end else if (busy_cnt != 0) begin
                pend_q <= 1'b0;
            end else if (pend_q) begin  // second cycle programs
                pend_q   <= 1'b0;
                pa_q     <= cmd_a[3:0];
                pd_q     <= cmd_d;
                abort_q  <= 1'b0;
                tog_q    <= 1'b0;
                if (!prot_q) busy_cnt <= PROG_CYC;
            end else if (era_q) begin  // sector is the upper bits
                era_q <= 1'b0;
                for (int i = 0; i < 16; i++)
                    if (cmd_d == 8'h10 ||
                        (cmd_d == 8'h30 && 2'(i >> 2) == cmd_a[3:2]))
                        mem[i] <= 8'hff;
            end else if (cmd_d == 8'h80) era_q <= 1'b1;
            else if (cmd_d == 8'h20) fast_q <= 1'b1;
            else if (cmd_d == 8'ha0 && fast_q) pend_q <= 1'b1;
            else if (cmd_d == 8'h90) id_q <= 1'b1;
            else if (cmd_d == 8'hf0) id_q <= 1'b0;
        end
    end
endmodule // fbod_flash_model

// *** testbench/tb_flash_bus_operation_decoder.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// host controller against the flash model
// ----------------------------------------------------------------------
module tb_flash_bus_operation_decoder;
    logic                clk = 1'b0;
    logic                reset = 1'b1;
    fbod_pkg::fbod_req_t req = '0;
    logic                req_valid = 1'b0;
    logic                req_ready, rsp_valid, op_done_seen, data_oe, done_pin;
    logic [7:0]          rsp_data, data_out, bus;
    logic [19:0]         address_pins;
    fbod_pkg::fbod_ctl_t ctl_pins;
    logic [15:0]         exp_q [$];  // {mask, value}
    logic [7:0]          shadow [16];
    logic [31:0]         rnd = 32'h0000000d;
    int                  num_errors = 0;
    int                  num_checks = 0;

    initial forever #4 clk = ~clk;

    fbod_host i_dut (.clk(clk), .reset(reset), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .op_done_seen(op_done_seen),
        .ctl_pins(ctl_pins), .address_pins(address_pins),
        .data_out(data_out), .data_oe(data_oe), .data_in(bus),
        .op_done_flag(done_pin));
    fbod_flash_model i_dev (.clk(clk), .ctl(ctl_pins), .addr(address_pins),
        .host_d(data_out), .host_oe(data_oe), .bus(bus),
        .op_done_flag(done_pin));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic report(input string msg);
        num_errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [15:0] e);
        num_checks++;
        if ((got & e[15:8]) !== (e[7:0] & e[15:8])) report("read data");
    endtask
    task automatic check_flag(input logic got, input logic e);
        num_checks++;
        if (got !== e) report("ready flag");
    endtask
    // bounded waits at the falling edge, away from launch edges
    task automatic wait_ready();
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 500);
        if (n >= 500) report("request not taken");
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (op_done_seen !== 1'b1 && n < 900);
        if (n >= 900) report("program never ended");
    endtask
    task automatic do_req(input fbod_pkg::fbod_op_t op, input logic [19:0] a,
                          input logic [7:0] d);
        wait_ready();
        @(posedge clk);
        req       <= '{op, a, d};
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        exp_q.push_back({m, e});
        do_req(fbod_pkg::FBOD_OP_READ, a, 8'h00);
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        do_req(fbod_pkg::FBOD_OP_WRITE, a, d);
    endtask
    task automatic prog(input logic [19:0] a, input logic [7:0] d);
        wr(20'h00555, 8'ha0);
        wr(a, d);
        wait_ready();
    endtask
    task automatic summarize();
        if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // each read result takes the oldest note; sampled mid-cycle
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) report("read without note");
            else check_byte(rsp_data, exp_q.pop_front());
        end
    end

    initial begin
        repeat (10000) @(posedge clk);
        report("run timed out");
        summarize();
    end

    initial begin
        logic [19:0] a;
        logic [7:0]  d;
        for (int i = 0; i < 16; i++) shadow[i] = 8'h5a ^ (8'(i) * 8'h11);
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(20'h00003, shadow[3], 8'hff);
        wait_ready();
        check_flag(op_done_seen, 1'b1);
        wr(20'h00555, 8'h20);
        // random programs, status polled while busy
        repeat (3) begin
            rnd = xorshift(rnd);
            a = rnd[19:0];
            d = rnd[27:20];
            prog(a, d);
            check_flag(op_done_seen, 1'b0);
            rd(a, {~d[7], 7'h40}, 8'hc0);
            rd(a, {~d[7], 7'h00}, 8'hc0);
            wait_done();
            shadow[a[3:0]] = d;
            rd(a, d, 8'hff);
            rd(a ^ 20'h00001, shadow[a[3:0] ^ 4'h1], 8'hff);
        end
        wr(20'h00555, 8'h90);
        rd(20'h00000, i_dev.ID_CODE, 8'hff);
        wr(20'h00000, 8'hf0);
        rd(20'h00005, shadow[5], 8'hff);
        // sector erase clears bytes 4 to 7 only
        wr(20'h00555, 8'h80);
        wr(20'h00004, 8'h30);
        for (int i = 4; i < 8; i++) shadow[i] = 8'hff;
        rd(20'h00006, 8'hff, 8'hff);
        rd(20'h00003, shadow[3], 8'hff);
        do_req(fbod_pkg::FBOD_OP_STANDBY, 20'h00000, 8'h00);
        rd(20'h00007, shadow[7], 8'hff);
        // protected array refuses the program, unprotect lets it in
        do_req(fbod_pkg::FBOD_OP_PROTECT, 20'h00000, 8'h00);
        prog(20'h00009, ~shadow[9]);
        rd(20'h00009, shadow[9], 8'hff);
        do_req(fbod_pkg::FBOD_OP_UNPROTECT, 20'h00000, 8'h00);
        prog(20'h00009, 8'h3c);
        wait_done();
        shadow[9] = 8'h3c;
        rd(20'h00009, 8'h3c, 8'hff);
        // reset in mid-program aborts, then the program is reissued
        d = ~shadow[2];
        prog(20'h00002, d);
        do_req(fbod_pkg::FBOD_OP_RESET, 20'h00000, 8'h00);
        wait_ready();
        check_flag(op_done_seen, 1'b1);
        rd(20'h00002, shadow[2], 8'hff);
        wr(20'h00555, 8'h20);
        prog(20'h00002, d);
        wait_done();
        rd(20'h00002, d, 8'hff);
        // whole-array erase
        wr(20'h00555, 8'h80);
        wr(20'h00555, 8'h10);
        rd(20'h0000b, 8'hff, 8'hff);
        wait_ready();
        if (exp_q.size() != 0) report("read result missing");
        summarize();
    end
endmodule // tb_flash_bus_operation_decoder
